// ===== hw/tbs_event_detect.sv
`default_nettype none

// =====================================================
// event trigger detector
module tbs_event_detect
  import tbs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sig_i,
  input wire logic [1:0] mode_i,
  output logic hit_o
);

  logic prev_q;
  logic prev_d;

  // previous level for edge detection
  always_comb begin
    prev_d = sig_i;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // reserved code raises nothing, safest reading
  always_comb begin
    unique case (mode_i)
      TBS_TRIG_RISE: hit_o = sig_i & ~prev_q;
      TBS_TRIG_FALL: hit_o = ~sig_i & prev_q;
      TBS_TRIG_LEVEL: hit_o = sig_i;
      TBS_TRIG_RSVD: hit_o = 1'b0;
    endcase
  end

endmodule : tbs_event_detect

`default_nettype wire

// ===== hw/tbs_pkg.sv
// Function
// - two-bit select routes one of four inputs
// - source 00 leaves user buffers untouched
// - source 01 loads user buffers from host
// - source 10 loads from received buffers
// - source 11: host first ten, receiver rest
// - validity select 0 inserts software validity
// - validity select 1 passes receiver validity
// - transfer done sets flag if enabled, unmasked
// - transfer flag drives interrupt and summary
// - slip or block start sets slip flag
// - slip source select picks the condition
// - slip flag drives interrupt and summary
// - status register read-only, upper bits zero
// - transfer mask 0 masks, default masked
// - slip mask 0 masks, default masked
// - trigger modes rising, falling, level, reserved
`default_nettype none

package tbs_pkg;

  // =====================================================
  // register offsets
  localparam logic [7:0] TBS_ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] TBS_ADDR_SRC_CTRL = 8'h09;
  localparam logic [7:0] TBS_ADDR_STATUS = 8'h0a;
  localparam logic [7:0] TBS_ADDR_MASK = 8'h0b;

  // =====================================================
  // field positions
  localparam int TBS_BYP_LSB = 0;
  localparam int TBS_XFER_DIS_BIT = 2;
  localparam int TBS_SRC_LSB = 0;
  localparam int TBS_VALIDITY_SOURCE_SELECT_BIT = 2;
  localparam int TBS_DONE_BIT = 0;
  localparam int TBS_SLIP_BIT = 1;

  // =====================================================
  // reset values
  localparam logic [1:0] TBS_BYP_RST = 2'h0;
  localparam logic TBS_XFER_DIS_RST = 1'b0;
  localparam logic [1:0] TBS_SRC_RST = 2'h0;
  localparam logic TBS_VALIDITY_SOURCE_SELECT_RST = 1'b0;
  localparam logic [1:0] TBS_MASK_RST = 2'h0;

  // =====================================================
  // buffer source codes
  localparam logic [1:0] TBS_SRC_NONE = 2'h0;
  localparam logic [1:0] TBS_SRC_HOST = 2'h1;
  localparam logic [1:0] TBS_SRC_RECV = 2'h2;
  localparam logic [1:0] TBS_SRC_SPLIT = 2'h3;
  localparam logic [7:0] TBS_HOST_BYTES = 8'h0a;

  // =====================================================
  // trigger mode codes
  localparam logic [1:0] TBS_TRIG_RISE = 2'h0;
  localparam logic [1:0] TBS_TRIG_FALL = 2'h1;
  localparam logic [1:0] TBS_TRIG_LEVEL = 2'h2;
  localparam logic [1:0] TBS_TRIG_RSVD = 2'h3;

endpackage : tbs_pkg

`default_nettype wire

// ===== hw/tbs_top.sv
`default_nettype none

// =====================================================
// transmitter buffer source and event registers
module tbs_top
  import tbs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  // host register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // line receiver outputs, asynchronous pins
  input wire logic line_input_one_i,
  input wire logic line_input_two_i,
  input wire logic line_input_three_i,
  input wire logic line_input_four_i,
  output logic bypass_out_o,
  // host and receiver buffer byte streams
  input wire logic host_ua_wr_i,
  input wire logic [7:0] host_ua_idx_i,
  input wire logic [7:0] host_ua_data_i,
  input wire logic ra_valid_i,
  input wire logic [7:0] ra_idx_i,
  input wire logic [7:0] ra_data_i,
  output logic ua_wr_o,
  output logic [7:0] ua_idx_o,
  output logic [7:0] ua_data_o,
  // validity
  input wire logic sw_validity_i,
  input wire logic rx_validity_i,
  output logic validity_o,
  // event sources and settings from neighbouring registers
  input wire logic buffer_transfer_done_i,
  input wire logic data_slip_i,
  input wire logic block_start_i,
  input wire logic slip_source_select_i,
  input wire logic [1:0] buffer_done_trigger_mode_i,
  input wire logic [1:0] slip_trigger_mode_i,
  output logic int_n_o,
  output logic tx_summary_o
);

  // =====================================================
  // register file
  logic [1:0] bypass_input_select_q, bypass_input_select_d;
  logic buffer_transfer_disable_q, buffer_transfer_disable_d;
  logic [1:0] aux_buffer_source_select_q, aux_buffer_source_select_d;
  logic validity_source_select_q, validity_source_select_d;
  logic buffer_transfer_done_mask_q, buffer_transfer_done_mask_d;
  logic source_slip_mask_q, source_slip_mask_d;
  logic [7:0] rdata_q, rdata_d;
  logic rd_status;

  assign rd_status = reg_rd_i && (reg_addr_i == TBS_ADDR_STATUS);

  // host writes; status register ignores writes
  always_comb begin
    bypass_input_select_d = bypass_input_select_q;
    buffer_transfer_disable_d = buffer_transfer_disable_q;
    aux_buffer_source_select_d = aux_buffer_source_select_q;
    validity_source_select_d = validity_source_select_q;
    buffer_transfer_done_mask_d = buffer_transfer_done_mask_q;
    source_slip_mask_d = source_slip_mask_q;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        TBS_ADDR_CTRL2: begin
          bypass_input_select_d = reg_wdata_i[TBS_BYP_LSB +: 2];
          buffer_transfer_disable_d = reg_wdata_i[TBS_XFER_DIS_BIT];
        end
        TBS_ADDR_SRC_CTRL: begin
          aux_buffer_source_select_d = reg_wdata_i[TBS_SRC_LSB +: 2];
          validity_source_select_d = reg_wdata_i[TBS_VALIDITY_SOURCE_SELECT_BIT];
        end
        TBS_ADDR_MASK: begin
          buffer_transfer_done_mask_d = reg_wdata_i[TBS_DONE_BIT];
          source_slip_mask_d = reg_wdata_i[TBS_SLIP_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bypass_input_select_q <= TBS_BYP_RST;
      buffer_transfer_disable_q <= TBS_XFER_DIS_RST;
      aux_buffer_source_select_q <= TBS_SRC_RST;
      validity_source_select_q <= TBS_VALIDITY_SOURCE_SELECT_RST;
      buffer_transfer_done_mask_q <= TBS_MASK_RST[TBS_DONE_BIT];
      source_slip_mask_q <= TBS_MASK_RST[TBS_SLIP_BIT];
    end else begin
      bypass_input_select_q <= bypass_input_select_d;
      buffer_transfer_disable_q <= buffer_transfer_disable_d;
      aux_buffer_source_select_q <= aux_buffer_source_select_d;
      validity_source_select_q <= validity_source_select_d;
      buffer_transfer_done_mask_q <= buffer_transfer_done_mask_d;
      source_slip_mask_q <= source_slip_mask_d;
    end
  end

  // =====================================================
  // event flags
  logic [1:0] flags_q, flags_d;
  logic done_hit, slip_sig, slip_hit, done_set, slip_set;
  logic int_n_q, int_n_d, summary_q, summary_d;

  tbs_event_detect u_done_detect (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .sig_i(buffer_transfer_done_i),
    .mode_i(buffer_done_trigger_mode_i),
    .hit_o(done_hit)
  );

  // chosen slip condition feeds the trigger detector
  assign slip_sig = slip_source_select_i ? block_start_i : data_slip_i;

  tbs_event_detect u_slip_detect (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .sig_i(slip_sig),
    .mode_i(slip_trigger_mode_i),
    .hit_o(slip_hit)
  );

  assign done_set = done_hit && !buffer_transfer_disable_q && buffer_transfer_done_mask_q;
  assign slip_set = slip_hit && source_slip_mask_q;

  // a new event in the clearing read wins, so no event is lost
  always_comb begin
    flags_d = flags_q;
    if (rd_status) begin
      flags_d = 2'h0;
    end
    if (done_set) begin
      flags_d[TBS_DONE_BIT] = 1'b1;
    end
    if (slip_set) begin
      flags_d[TBS_SLIP_BIT] = 1'b1;
    end
    int_n_d = ~|flags_d;
    summary_d = |flags_d;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flags_q <= 2'h0;
      int_n_q <= 1'b1;
      summary_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      int_n_q <= int_n_d;
      summary_q <= summary_d;
    end
  end

  // =====================================================
  // read data, registered one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        TBS_ADDR_CTRL2: begin
          rdata_d[TBS_BYP_LSB +: 2] = bypass_input_select_q;
          rdata_d[TBS_XFER_DIS_BIT] = buffer_transfer_disable_q;
        end
        TBS_ADDR_SRC_CTRL: begin
          rdata_d[TBS_SRC_LSB +: 2] = aux_buffer_source_select_q;
          rdata_d[TBS_VALIDITY_SOURCE_SELECT_BIT] = validity_source_select_q;
        end
        TBS_ADDR_STATUS: begin
          rdata_d[1:0] = flags_q;
        end
        TBS_ADDR_MASK: begin
          rdata_d[TBS_DONE_BIT] = buffer_transfer_done_mask_q;
          rdata_d[TBS_SLIP_BIT] = source_slip_mask_q;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // =====================================================
  // bypass multiplexer
  logic [3:0] line_meta_q, line_meta_d, line_sync_q, line_sync_d;
  logic bypass_q, bypass_d, bypass_pick;

  assign bypass_pick = line_sync_q[bypass_input_select_q];

  // pins are asynchronous, so two flops before the mux
  always_comb begin
    line_meta_d = {line_input_four_i, line_input_three_i, line_input_two_i, line_input_one_i};
    line_sync_d = line_meta_q;
    bypass_d = bypass_pick;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      line_meta_q <= 4'h0;
      line_sync_q <= 4'h0;
      bypass_q <= 1'b0;
    end else begin
      line_meta_q <= line_meta_d;
      line_sync_q <= line_sync_d;
      bypass_q <= bypass_d;
    end
  end

  // =====================================================
  // user buffer loader and validity
  logic ua_wr_q, ua_wr_d, validity_q, validity_d;
  logic [7:0] ua_idx_q, ua_idx_d, ua_data_q, ua_data_d;
  logic host_low;

  assign host_low = host_ua_idx_i < TBS_HOST_BYTES;

  // host wins a same-cycle clash in split mode
  always_comb begin
    ua_wr_d = 1'b0;
    ua_idx_d = ua_idx_q;
    ua_data_d = ua_data_q;
    unique case (aux_buffer_source_select_q)
      TBS_SRC_NONE: begin
        ua_wr_d = 1'b0;
      end
      TBS_SRC_HOST: begin
        if (host_ua_wr_i) begin
          ua_wr_d = 1'b1;
          ua_idx_d = host_ua_idx_i;
          ua_data_d = host_ua_data_i;
        end
      end
      TBS_SRC_RECV: begin
        if (ra_valid_i) begin
          ua_wr_d = 1'b1;
          ua_idx_d = ra_idx_i;
          ua_data_d = ra_data_i;
        end
      end
      TBS_SRC_SPLIT: begin
        if (host_ua_wr_i && host_low) begin
          ua_wr_d = 1'b1;
          ua_idx_d = host_ua_idx_i;
          ua_data_d = host_ua_data_i;
        end else if (ra_valid_i && (ra_idx_i >= TBS_HOST_BYTES)) begin
          ua_wr_d = 1'b1;
          ua_idx_d = ra_idx_i;
          ua_data_d = ra_data_i;
        end
      end
    endcase
    // both sources see the same single register stage
    validity_d = validity_source_select_q ? rx_validity_i : sw_validity_i;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ua_wr_q <= 1'b0;
      ua_idx_q <= 8'h00;
      ua_data_q <= 8'h00;
      validity_q <= 1'b0;
    end else begin
      ua_wr_q <= ua_wr_d;
      ua_idx_q <= ua_idx_d;
      ua_data_q <= ua_data_d;
      validity_q <= validity_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign bypass_out_o = bypass_q;
  assign ua_wr_o = ua_wr_q;
  assign ua_idx_o = ua_idx_q;
  assign ua_data_o = ua_data_q;
  assign validity_o = validity_q;
  assign int_n_o = int_n_q;
  assign tx_summary_o = summary_q;

  // =====================================================
  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence s_status_read;
    rd_status;
  endsequence

  sequence s_host_byte;
    host_ua_wr_i && host_low;
  endsequence

  chk_bypass_route: assert property (
    1'b1 |=> bypass_out_o == $past(bypass_pick))
    else $error("bypass output not the selected input");

  chk_source_none: assert property (
    aux_buffer_source_select_q == TBS_SRC_NONE |=> !ua_wr_o)
    else $error("user buffer written with source off");

  chk_source_host: assert property (
    aux_buffer_source_select_q == TBS_SRC_HOST && host_ua_wr_i
    |=> ua_wr_o && ua_data_o == $past(host_ua_data_i))
    else $error("host byte not loaded");

  chk_source_recv: assert property (
    aux_buffer_source_select_q == TBS_SRC_RECV && ra_valid_i
    |=> ua_wr_o && ua_data_o == $past(ra_data_i))
    else $error("received byte not loaded");

  chk_split_host: assert property (
    aux_buffer_source_select_q == TBS_SRC_SPLIT ##0 s_host_byte
    |=> ua_wr_o && ua_idx_o == $past(host_ua_idx_i))
    else $error("split mode lost a low host byte");

  chk_split_recv_low: assert property (
    aux_buffer_source_select_q == TBS_SRC_SPLIT && !host_ua_wr_i
    && ra_valid_i && ra_idx_i < TBS_HOST_BYTES |=> !ua_wr_o)
    else $error("split mode took a low receiver byte");

  chk_valid_sw: assert property (
    !validity_source_select_q |=> validity_o == $past(sw_validity_i))
    else $error("software validity not inserted");

  chk_valid_rx: assert property (
    validity_source_select_q |=> validity_o == $past(rx_validity_i))
    else $error("receiver validity not passed");

  chk_done_set: assert property (
    done_hit && buffer_transfer_done_mask_q && !buffer_transfer_disable_q
    |=> flags_q[TBS_DONE_BIT] && !int_n_o)
    else $error("transfer done flag not set");

  chk_int_follow: assert property (
    int_n_o == !(|flags_q) && tx_summary_o == (|flags_q))
    else $error("interrupt does not follow flags");

  chk_slip_set: assert property (
    slip_hit && source_slip_mask_q |=> flags_q[TBS_SLIP_BIT] [*1] ##0 tx_summary_o)
    else $error("slip flag not set");

  chk_status_read: assert property (
    s_status_read |=> reg_rdata_o[7:2] == 6'h00 && reg_rdata_o[1:0] == $past(flags_q))
    else $error("status readback wrong");

  chk_done_masked: assert property (
    !flags_q[TBS_DONE_BIT] && !buffer_transfer_done_mask_q |=> !flags_q[TBS_DONE_BIT])
    else $error("masked transfer done set flag");

  chk_slip_masked: assert property (
    !flags_q[TBS_SLIP_BIT] && !source_slip_mask_q |=> !flags_q[TBS_SLIP_BIT])
    else $error("masked slip set flag");

  chk_trig_rsvd: assert property (
    slip_trigger_mode_i == TBS_TRIG_RSVD && !flags_q[TBS_SLIP_BIT] |=> !flags_q[TBS_SLIP_BIT])
    else $error("reserved trigger mode raised slip");

  chk_read_clear: assert property (
    s_status_read ##0 !done_set ##0 !slip_set |=> flags_q == 2'h0 ##0 int_n_o)
    else $error("status read did not clear flags");

endmodule : tbs_top

`default_nettype wire

// ===== verification/tbs_host_model.sv
`default_nettype none

// =====================================================
// host processor model: register strobes and buffer bytes
module tbs_host_model (
  input wire logic clock_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  output logic host_ua_wr_o,
  output logic [7:0] host_ua_idx_o,
  output logic [7:0] host_ua_data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
    {host_ua_wr_o, host_ua_idx_o, host_ua_data_o} = '0;
  end

  // released lines show the inverse so stale values never pass
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clock_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  // read data is taken in the cycle after the strobe edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clock_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask

  // host supplies user buffer bytes itself
  task automatic host_byte(input logic [7:0] i, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    host_ua_idx_o = i;
    host_ua_data_o = d;
    host_ua_wr_o = 1'b1;
    @(posedge clock_i);
    #1;
    host_ua_wr_o = 1'b0;
    host_ua_idx_o = ~i;
    host_ua_data_o = ~d;
  endtask
endmodule // tbs_host_model

`default_nettype wire

// ===== verification/test_tbs_top.sv
`default_nettype none

// =====================================================
// bench for the transmitter source and event registers
module test_tbs_top;
  import tbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0, rst = 1'b1;
  logic [7:0] addr, wdata, rdata, hidx, hdata, ra_idx, ra_data, uidx, udata, v;
  logic wr, rd, hwr, ra_valid, uwr, byp, sw_val, rx_val, val, sel, int_n, summ;
  logic [3:0] lines;
  logic [2:0] ev;
  logic [1:0] done_mode, slip_mode;
  int mismatches = 0, comparisons = 0, cycles = 0;

  // =====================================================
  // clock, partner and design
  always #50 clock = ~clock;

  tbs_host_model u_host (.clock_i(clock), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata), .host_ua_wr_o(hwr),
    .host_ua_idx_o(hidx), .host_ua_data_o(hdata));

  tbs_top u_dut (.clock_i(clock), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .line_input_one_i(lines[0]),
    .line_input_two_i(lines[1]), .line_input_three_i(lines[2]),
    .line_input_four_i(lines[3]), .bypass_out_o(byp), .host_ua_wr_i(hwr),
    .host_ua_idx_i(hidx), .host_ua_data_i(hdata), .ra_valid_i(ra_valid),
    .ra_idx_i(ra_idx), .ra_data_i(ra_data), .ua_wr_o(uwr), .ua_idx_o(uidx),
    .ua_data_o(udata), .sw_validity_i(sw_val), .rx_validity_i(rx_val),
    .validity_o(val), .buffer_transfer_done_i(ev[0]), .data_slip_i(ev[1]),
    .block_start_i(ev[2]), .slip_source_select_i(sel),
    .buffer_done_trigger_mode_i(done_mode), .slip_trigger_mode_i(slip_mode),
    .int_n_o(int_n), .tx_summary_o(summ));

  // =====================================================
  // shared tasks
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // receiver buffer byte, same strobe timing as the host
  task automatic rx_byte(input logic [7:0] i, input logic [7:0] d);
    tick(1);
    {ra_idx, ra_data, ra_valid} = {i, d, 1'b1};
    tick(1);
    {ra_idx, ra_data, ra_valid} = {~i, ~d, 1'b0};
  endtask

  // user buffer write pulse stands for the cycle after the strobe
  task automatic ua_check(input logic w, input logic [7:0] i, input logic [7:0] d);
    check({7'h00, uwr}, {7'h00, w});
    if (w) check({uidx ^ i} | {udata ^ d}, 8'h00);
  endtask

  task automatic status(input logic [7:0] exp);
    u_host.read_reg(TBS_ADDR_STATUS, v);
    check(v, exp);
  endtask

  // one event pulse, then interrupt, summary and status
  task automatic ev_check(input int k, input logic [7:0] exp);
    ev[k] = 1'b1;
    tick(2);
    ev[k] = 1'b0;
    tick(2);
    check({7'h00, int_n}, {7'h00, exp == 8'h00});
    check({7'h00, summ}, {7'h00, exp != 8'h00});
    status(exp);
  endtask

  // =====================================================
  // hang guard, far above the roughly 230 cycles used
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // =====================================================
  // main sequence
  initial begin
    {lines, ev, done_mode, slip_mode, sel, sw_val, rx_val} = '0;
    {ra_idx, ra_data, ra_valid} = '0;
    tick(16);
    rst = 1'b0;
    u_host.read_reg(TBS_ADDR_CTRL2, v);
    check(v, 8'h00);
    u_host.read_reg(TBS_ADDR_SRC_CTRL, v);
    check(v, 8'h00);
    u_host.read_reg(TBS_ADDR_MASK, v);
    check(v, 8'h00);
    u_host.read_reg(8'h3f, v);
    check(v, 8'h00);
    status(8'h00);
    ev_check(0, 8'h00);
    for (int b = 0; b < 4; b++) begin
      u_host.write_reg(TBS_ADDR_CTRL2, 8'(b));
      lines = 4'h1 << b;
      tick(4);
      check({7'h00, byp}, 8'h01);
      lines = ~(4'h1 << b);
      tick(4);
      check({7'h00, byp}, 8'h00);
    end
    for (int s = 0; s < 4; s++) begin
      u_host.write_reg(TBS_ADDR_SRC_CTRL, 8'(s));
      u_host.host_byte(8'h09, 8'h5a);
      ua_check(s[0], 8'h09, 8'h5a);
      u_host.host_byte(TBS_HOST_BYTES, 8'h3c);
      ua_check(s == 1, TBS_HOST_BYTES, 8'h3c);
      rx_byte(8'h09, 8'ha5);
      ua_check(s == 2, 8'h09, 8'ha5);
      rx_byte(TBS_HOST_BYTES, 8'hc3);
      ua_check(s[1], TBS_HOST_BYTES, 8'hc3);
    end
    for (int k = 0; k < 2; k++) begin
      u_host.write_reg(TBS_ADDR_SRC_CTRL, k ? 8'h04 : 8'h00);
      {sw_val, rx_val} = 2'b10;
      tick(2);
      check({7'h00, val}, {7'h00, k == 0});
      {sw_val, rx_val} = 2'b01;
      tick(2);
      check({7'h00, val}, {7'h00, k == 1});
    end
    u_host.write_reg(TBS_ADDR_MASK, 8'h03);
    for (int m = 0; m < 4; m++) begin
      done_mode = 2'(m);
      ev_check(0, m == 3 ? 8'h00 : 8'h01);
      tick(1);
      check({7'h00, int_n}, 8'h01);
      status(8'h00);
    end
    done_mode = TBS_TRIG_RISE;
    u_host.write_reg(TBS_ADDR_STATUS, 8'hff);
    status(8'h00);
    u_host.write_reg(TBS_ADDR_CTRL2, 8'h04);
    ev_check(0, 8'h00);
    u_host.write_reg(TBS_ADDR_CTRL2, 8'h00);
    ev_check(2, 8'h00);
    ev_check(1, 8'h02);
    sel = 1'b1;
    ev_check(1, 8'h00);
    ev_check(2, 8'h02);
    // slip detector in falling, level and reserved modes, reserved raises nothing
    for (int m = 1; m < 4; m++) begin
      slip_mode = 2'(m);
      ev_check(2, m == 3 ? 8'h00 : 8'h02);
    end
    slip_mode = TBS_TRIG_RISE;
    u_host.write_reg(TBS_ADDR_MASK, 8'h01);
    ev_check(2, 8'h00);
    end_of_test();
  end
endmodule // test_tbs_top

`default_nettype wire
